//--- core/wlsu_pkg.sv
package wlsu_pkg;

  // Operand spaces and limits
  localparam int DATA_REGS = 100;
  localparam int TC_NUM = 32;
  localparam logic [16:0] DATA_LAST = 17'h0_0063;
  localparam logic [16:0] DATA_LAST_HS = 17'h0_001F;
  localparam logic [16:0] TC_LAST = 17'h0_001F;
  localparam logic [16:0] IN_LAST = 17'h0_0023;
  localparam logic [15:0] PRESET_MAX = 16'h270F;
  localparam logic [3:0] SHIFT_MIN = 4'h1;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Register byte addresses
  localparam logic [11:0] ADR_CFG = 12'h000;
  localparam logic [11:0] ADR_SRC1 = 12'h004;
  localparam logic [11:0] ADR_SRC2 = 12'h008;
  localparam logic [11:0] ADR_DST = 12'h00C;
  localparam logic [11:0] ADR_COUNT = 12'h010;
  localparam logic [11:0] ADR_STATUS = 12'h014;
  localparam logic [11:0] ADR_IRQ_STAT = 12'h018;
  localparam logic [11:0] ADR_IRQ_MASK = 12'h01C;
  localparam logic [11:0] DATA_BASE = 12'h400;
  localparam logic [11:0] DATA_SPAN = 12'h190;
  localparam logic [11:0] TPRE_BASE = 12'h600;
  localparam logic [11:0] CPRE_BASE = 12'h680;

  // Field positions
  localparam int CNT_REP_LSB = 0;
  localparam int CNT_SHIFT_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;

  typedef enum logic [1:0] {OP_AND, OP_OR, OP_XOR, OP_SHL} wlsu_op_t;
  typedef enum logic [2:0] {K_DATA, K_TIMER, K_COUNTER, K_CONST, K_INPUT} wlsu_kind_t;

  // Instruction configuration word, bit 0 upward: op, kinds, repeat flags, speed mode
  typedef struct packed {
    logic hiSpeed;
    logic dRep;
    logic s2Rep;
    logic s1Rep;
    wlsu_kind_t dKind;
    wlsu_kind_t s2Kind;
    wlsu_kind_t s1Kind;
    wlsu_op_t op;
  } wlsu_cfg_t;

  // Wishbone request bundle from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:2] adr;
    logic [31:0] dat;
  } wlsu_wbreq_t;

endpackage : wlsu_pkg

//--- core/wlsu_word_logic_shift_unit.sv
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module wlsu_word_logic_shift_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire wlsu_pkg::wlsu_wbreq_t wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Scan executor
  input wire logic scanStart,
  input wire logic instrEnable,
  input wire logic [15:0] inputImage,
  input wire logic [31:0][15:0] timerCurrent,
  input wire logic [31:0][15:0] counterCurrent,
  output logic busy,
  output logic done,
  // Preset values
  output logic [31:0][15:0] timerPreset,
  output logic [31:0][15:0] counterPreset,
  // Indicators
  output logic errorLamp,
  output logic execErrorRelay,
  output logic carryRelay,
  output logic irq
);
  import wlsu_pkg::*;

  typedef enum {ST_IDLE, ST_CHECK, ST_WRITE} wlsu_state_t;

  wlsu_state_t state_q;
  wlsu_cfg_t cfg_q;
  logic [15:0] s1Arg_q;
  logic [15:0] s2Arg_q;
  logic [15:0] dArg_q;
  logic [4:0] rep_q;
  logic [4:0] idx_q;
  logic [3:0] shiftCnt_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  logic err_q;
  logic carry_q;
  logic ack_q;
  logic done_q;
  logic [31:0] rdData_q;
  logic [15:0] dataMem [DATA_REGS];
  logic [15:0] resBuf [TC_NUM];

  // Operand value by kind
  function automatic logic [15:0] pick(input wlsu_kind_t k, input logic [15:0] arg,
      input logic [15:0] dv, input logic [15:0] tv, input logic [15:0] cv,
      input logic [15:0] iv);
    unique case (k)
      K_DATA: pick = dv;
      K_TIMER: pick = tv;
      K_COUNTER: pick = cv;
      K_CONST: pick = arg;
      K_INPUT: pick = iv;
      default: pick = WORD_RST;
    endcase
  endfunction : pick

  // Last operand address lies inside the space of its kind
  function automatic logic fits(input wlsu_kind_t k, input logic [16:0] last);
    unique case (k)
      K_DATA: fits = last <= DATA_LAST;
      K_TIMER, K_COUNTER: fits = last <= TC_LAST;
      K_INPUT: fits = last <= IN_LAST;
      K_CONST: fits = 1'b1;
      default: fits = 1'b0;
    endcase
  endfunction : fits

  // Data register index, forced to 0 so a stray address never reads past the array
  function automatic logic [6:0] memIdx(input logic [15:0] adr);
    memIdx = (adr <= DATA_LAST[15:0]) ? adr[6:0] : 7'h00;
  endfunction : memIdx

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] wmask(input logic [15:0] old, input logic [31:0] dat,
      input logic [3:0] sel);
    wmask = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : wmask

  // Repeat count and operand addresses for the current cycle
  wire isShift = cfg_q.op == OP_SHL;
  wire anyRep = cfg_q.s1Rep | cfg_q.s2Rep | cfg_q.dRep;
  wire [4:0] nCyc = (anyRep && rep_q != 5'h00) ? rep_q : 5'h01;
  wire [4:0] nMinus = nCyc - 5'h01;
  wire [16:0] nLast = {12'h000, nMinus};
  wire [16:0] s1Last = {1'b0, s1Arg_q} + (cfg_q.s1Rep ? nLast : 17'h0_0000);
  wire [16:0] s2Last = {1'b0, s2Arg_q} + (cfg_q.s2Rep ? nLast : 17'h0_0000);
  wire [16:0] dLast = {1'b0, dArg_q} + (cfg_q.dRep ? nLast : 17'h0_0000);
  wire [15:0] idxExt = {11'h000, idx_q};
  wire [15:0] s1Adr = s1Arg_q + (cfg_q.s1Rep ? idxExt : 16'h0000);
  wire [15:0] s2Adr = s2Arg_q + (cfg_q.s2Rep ? idxExt : 16'h0000);
  wire [15:0] dAdr = dArg_q + (cfg_q.dRep ? idxExt : 16'h0000);

  // Operand fetch; timers and counters give their current value
  wire [15:0] s1Val = pick(cfg_q.s1Kind, s1Arg_q, dataMem[memIdx(s1Adr)],
      timerCurrent[s1Adr[4:0]], counterCurrent[s1Adr[4:0]], inputImage);
  wire [15:0] s2Val = pick(cfg_q.s2Kind, s2Arg_q, dataMem[memIdx(s2Adr)],
      timerCurrent[s2Adr[4:0]], counterCurrent[s2Adr[4:0]], inputImage);

  // Result: 16-bit word logic or left shift with carry in bit 16
  wire [16:0] shl17 = {1'b0, s1Val} << shiftCnt_q;
  wire shOut = shl17[16];
  wire [15:0] boolRes = (cfg_q.op == OP_AND) ? (s1Val & s2Val) :
      (cfg_q.op == OP_OR) ? (s1Val | s2Val) : (s1Val ^ s2Val);
  wire [15:0] res = isShift ? shl17[15:0] : boolRes;

  // Destination: shift writes back to its own data register
  wlsu_kind_t dKindEff;
  assign dKindEff = isShift ? K_DATA : cfg_q.dKind;
  wire [15:0] dAdrEff = isShift ? s1Arg_q : dAdr;
  wire dIsTc = dKindEff == K_TIMER || dKindEff == K_COUNTER;
  wire presetOver = dIsTc && res > PRESET_MAX;

  // Static operand checks made before anything is written
  wire [16:0] shLast = cfg_q.hiSpeed ? DATA_LAST_HS : DATA_LAST;
  wire shiftOk = cfg_q.s1Kind == K_DATA && !anyRep &&
      shiftCnt_q >= SHIFT_MIN && {1'b0, s1Arg_q} <= shLast;
  wire dKindOk = cfg_q.dKind == K_DATA || cfg_q.dKind == K_TIMER ||
      cfg_q.dKind == K_COUNTER;
  wire boolOk = dKindOk && fits(cfg_q.s1Kind, s1Last) && fits(cfg_q.s2Kind, s2Last) &&
      fits(cfg_q.dKind, dLast);
  wire staticOk = isShift ? shiftOk : boolOk;

  // Sequencing events
  wire startReq = state_q == ST_IDLE && scanStart && instrEnable;
  wire lastCyc = idx_q == nMinus;
  wire fault = (startReq && !staticOk) || (state_q == ST_CHECK && presetOver);
  wire engWr = state_q == ST_WRITE;
  wire finish = engWr && lastCyc;

  // Wishbone decode; register access is held off while an instruction runs
  wire wbReqV = wbReq.cyc && wbReq.stb && !ack_q && state_q == ST_IDLE;
  wire wbWr = wbReqV && wbReq.we;
  wire [15:0] cfgMerge = wmask(16'(cfg_q), wbReq.dat, wbReq.sel);
  wire [11:0] adr = {wbReq.adr, 2'b00};
  wire [11:0] dataOff = adr - DATA_BASE;
  wire selData = adr >= DATA_BASE && dataOff < DATA_SPAN;
  wire selTp = adr[11:7] == TPRE_BASE[11:7];
  wire selCp = adr[11:7] == CPRE_BASE[11:7];
  wire [31:0] rdMux =
      selData ? {16'h0000, dataMem[dataOff[8:2]]} :
      selTp ? {16'h0000, timerPreset[adr[6:2]]} :
      selCp ? {16'h0000, counterPreset[adr[6:2]]} :
      (adr == ADR_CFG) ? {17'h0_0000, cfg_q} :
      (adr == ADR_SRC1) ? {16'h0000, s1Arg_q} :
      (adr == ADR_SRC2) ? {16'h0000, s2Arg_q} :
      (adr == ADR_DST) ? {16'h0000, dArg_q} :
      (adr == ADR_COUNT) ? {20'h0_0000, shiftCnt_q, 3'h0, rep_q} :
      (adr == ADR_STATUS) ? {29'h0000_0000, carry_q, err_q, busy} :
      (adr == ADR_IRQ_STAT) ? {30'h0000_0000, irqStat_q} :
      (adr == ADR_IRQ_MASK) ? {30'h0000_0000, irqMask_q} : 32'h0000_0000;

  // Outputs
  assign wbAck = ack_q;
  assign wbDatO = rdData_q;
  assign busy = state_q != ST_IDLE;
  assign done = done_q;
  assign errorLamp = err_q;
  assign execErrorRelay = err_q;
  assign carryRelay = carry_q;
  assign irq = |(irqStat_q & irqMask_q);

  // Bus answer: one cycle after the request is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end else begin
      ack_q <= wbReqV;
      rdData_q <= rdMux;
    end
  end

  // Instruction configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= wlsu_cfg_t'(WORD_RST[14:0]);
      s1Arg_q <= WORD_RST;
      s2Arg_q <= WORD_RST;
      dArg_q <= WORD_RST;
      rep_q <= WORD_RST[4:0];
      shiftCnt_q <= WORD_RST[3:0];
      irqMask_q <= WORD_RST[1:0];
    end else if (wbWr) begin
      if (adr == ADR_CFG) cfg_q <= wlsu_cfg_t'(cfgMerge[14:0]);
      if (adr == ADR_SRC1) s1Arg_q <= wmask(s1Arg_q, wbReq.dat, wbReq.sel);
      if (adr == ADR_SRC2) s2Arg_q <= wmask(s2Arg_q, wbReq.dat, wbReq.sel);
      if (adr == ADR_DST) dArg_q <= wmask(dArg_q, wbReq.dat, wbReq.sel);
      if (adr == ADR_COUNT && wbReq.sel[0]) rep_q <= wbReq.dat[CNT_REP_LSB +: 5];
      if (adr == ADR_COUNT && wbReq.sel[1]) shiftCnt_q <= wbReq.dat[CNT_SHIFT_LSB +: 4];
      if (adr == ADR_IRQ_MASK && wbReq.sel[0]) irqMask_q <= wbReq.dat[1:0];
    end
  end

  // Sequencer: check pass computes and vets all results, write pass stores them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      idx_q <= 5'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          idx_q <= 5'h00;
          if (startReq && staticOk) state_q <= ST_CHECK;
        end
        ST_CHECK: begin
          if (presetOver) begin
            state_q <= ST_IDLE;
          end else if (lastCyc) begin
            state_q <= ST_WRITE;
            idx_q <= 5'h00;
          end else begin
            idx_q <= idx_q + 5'h01;
          end
        end
        ST_WRITE: begin
          if (lastCyc) state_q <= ST_IDLE;
          else idx_q <= idx_q + 5'h01;
        end
      endcase
    end
  end

  // Result buffer filled during the check pass
  always_ff @(posedge clk) begin
    if (state_q == ST_CHECK) resBuf[idx_q] <= res;
  end

  // Data registers and presets: engine writes, or bus writes while idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DATA_REGS; i++) dataMem[i] <= WORD_RST;
      for (int i = 0; i < TC_NUM; i++) timerPreset[i] <= WORD_RST;
      for (int i = 0; i < TC_NUM; i++) counterPreset[i] <= WORD_RST;
    end else if (engWr) begin
      unique case (dKindEff)
        K_DATA: dataMem[memIdx(dAdrEff)] <= resBuf[idx_q];
        K_TIMER: timerPreset[dAdrEff[4:0]] <= resBuf[idx_q];
        K_COUNTER: counterPreset[dAdrEff[4:0]] <= resBuf[idx_q];
        default: ;
      endcase
    end else if (wbWr) begin
      if (selData) dataMem[dataOff[8:2]] <= wmask(dataMem[dataOff[8:2]], wbReq.dat, wbReq.sel);
      if (selTp) timerPreset[adr[6:2]] <= wmask(timerPreset[adr[6:2]], wbReq.dat, wbReq.sel);
      if (selCp) counterPreset[adr[6:2]] <= wmask(counterPreset[adr[6:2]], wbReq.dat,
          wbReq.sel);
    end
  end

  // Error latch, carry, completion pulse and sticky interrupt status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_q <= 1'b0;
      carry_q <= 1'b0;
      done_q <= 1'b0;
      irqStat_q <= 2'h0;
    end else begin
      if (fault) err_q <= 1'b1;
      if (engWr && isShift) carry_q <= shOut;
      done_q <= finish | fault;
      irqStat_q <= (irqStat_q & ~((wbWr && adr == ADR_IRQ_STAT) ? wbReq.dat[1:0] : 2'h0))
          | {fault, finish};
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_xor_word: assert property (
    state_q == ST_CHECK && cfg_q.op == OP_XOR |-> res == (s1Val ^ s2Val))
    else $error("xor result wrong");
  chk_rescan_start: assert property (
    startReq && staticOk |=> state_q == ST_CHECK && idx_q == 5'h00)
    else $error("enabled scan did not start");
  chk_tc_current: assert property (
    state_q == ST_CHECK && cfg_q.s1Kind == K_TIMER |-> s1Val == timerCurrent[s1Adr[4:0]])
    else $error("timer source not current value");
  chk_preset_range: assert property (
    engWr && dIsTc |-> resBuf[idx_q] <= PRESET_MAX)
    else $error("preset write above limit");
  chk_preset_error: assert property (
    state_q == ST_CHECK && presetOver |=> err_q && errorLamp && execErrorRelay && !busy)
    else $error("preset overflow not flagged");
  chk_dest_kind: assert property (
    engWr |-> dKindEff == K_DATA || dIsTc)
    else $error("illegal destination written");
  chk_repeat_len: assert property (
    $rose(engWr) |-> $past(idx_q) == nMinus)
    else $error("check pass length wrong");
  chk_err_hold: assert property (
    err_q |=> err_q)
    else $error("error latch dropped");
  chk_fault_nowrite: assert property (
    fault |=> !engWr ##1 done_q == 1'b0 || !engWr)
    else $error("faulting instruction wrote");
  chk_shift_carry: assert property (
    engWr && isShift |=> carry_q == $past(shOut))
    else $error("carry not last bit out");
  chk_shift_norep: assert property (
    busy && isShift |-> !anyRep && nCyc == 5'h01)
    else $error("shift ran with repeat");
  chk_hs_limit: assert property (
    engWr && isShift && cfg_q.hiSpeed |-> {1'b0, s1Arg_q} <= DATA_LAST_HS)
    else $error("high-speed shift out of range");
  chk_single_run: assert property (
    busy && rep_q == 5'h00 |-> nCyc == 5'h01)
    else $error("zero repeat ran more than once");
  chk_shift_count: assert property (
    startReq && isShift && shiftCnt_q < SHIFT_MIN |-> fault)
    else $error("zero shift count accepted");
  chk_shift_rep: assert property (
    startReq && isShift && anyRep |-> fault)
    else $error("repeated shift accepted");
  chk_hs_refuse: assert property (
    startReq && isShift && cfg_q.hiSpeed && {1'b0, s1Arg_q} > DATA_LAST_HS |-> fault)
    else $error("high-speed shift range not refused");
  chk_dest_refuse: assert property (
    startReq && !isShift && (cfg_q.dKind == K_CONST || cfg_q.dKind == K_INPUT) |-> fault)
    else $error("input or constant destination accepted");
  chk_fault_idle: assert property (
    fault |=> !busy)
    else $error("faulting instruction kept running");
  chk_unrep_dest: assert property (
    engWr && !isShift && !cfg_q.dRep |-> dAdrEff == dArg_q)
    else $error("unrepeated destination moved");
  chk_ack_pulse: assert property (
    wbAck |=> !wbAck)
    else $error("bus answer longer than one cycle");

  // Busy run length; two passes of the repeat count at most
  logic [5:0] busyCnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !busy) begin
      busyCnt_q <= 6'h00;
    end else begin
      busyCnt_q <= busyCnt_q + 6'h01;
    end
  end

  chk_busy_bound: assert property (
    busy |-> busyCnt_q < {nCyc, 1'b0})
    else $error("instruction ran too long");

  cov_xor_repeat: cover property (finish && cfg_q.op == OP_XOR && cfg_q.dRep && cfg_q.s1Rep);
  cov_preset_fault: cover property (state_q == ST_CHECK && presetOver);
  cov_shift_done: cover property (finish && isShift);
  cov_rescan: cover property (finish ##2 startReq);
  cov_static_fault: cover property (startReq && !staticOk);

endmodule : wlsu_word_logic_shift_unit

//--- tb/wlsu_scan_exec.sv
`timescale 1ns/10ps
// Scan executor model: one scan tick per bench request, then waits for the unit
module wlsu_scan_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bench side
  input wire logic runReq,
  input wire logic enLevel,
  output logic runDone,
  // Unit side
  input wire logic done,
  output logic scanStart,
  output logic instrEnable
);
  logic active_q;
  logic [7:0] wait_q;

  // Rung enable is a level; a tick is only issued while idle
  always_ff @(posedge clk) begin
    scanStart <= 1'b0;
    runDone <= 1'b0;
    instrEnable <= enLevel;
    if (sys_rst) begin
      active_q <= 1'b0;
      wait_q <= 8'h00;
    end else if (runReq && !active_q && !runDone) begin
      scanStart <= 1'b1;
      active_q <= 1'b1;
      wait_q <= 8'h00;
    end else if (active_q) begin
      wait_q <= wait_q + 8'h01;
      // A disabled rung never answers, so give up after a short wait
      if (done || wait_q == 8'hC8 || (!instrEnable && wait_q == 8'h04)) begin
        runDone <= 1'b1;
        active_q <= 1'b0;
      end
    end
  end
endmodule : wlsu_scan_exec

//--- tb/word_logic_shift_unit_tb_top.sv
`timescale 1ns/10ps
module word_logic_shift_unit_tb_top;
  import wlsu_pkg::*;
  logic clk;
  logic sys_rst;
  wlsu_wbreq_t wbReq;
  logic [31:0] wbDatO;
  logic wbAck, scanStart, instrEnable, done, errorLamp, execErrorRelay, carryRelay, irq;
  logic [15:0] inputImage;
  logic [31:0][15:0] timerCurrent, counterCurrent;
  logic runReq, enLevel, runDone, rdPend, carry, err;
  logic [1:0] irqSt, irqMsk;
  logic [31:0] expQ[$];
  logic [15:0] mem [0:99];
  int nErrors, samplesChecked;

  wlsu_word_logic_shift_unit i_dut (.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq),
    .wbDatO(wbDatO), .wbAck(wbAck), .scanStart(scanStart), .instrEnable(instrEnable),
    .inputImage(inputImage), .timerCurrent(timerCurrent), .counterCurrent(counterCurrent),
    .busy(), .done(done), .timerPreset(), .counterPreset(), .errorLamp(errorLamp),
    .execErrorRelay(execErrorRelay), .carryRelay(carryRelay), .irq(irq));

  wlsu_scan_exec i_exec (.clk(clk), .sys_rst(sys_rst), .runReq(runReq), .enLevel(enLevel),
    .runDone(runDone), .done(done), .scanStart(scanStart), .instrEnable(instrEnable));

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [11:0] da(input int k);
    return DATA_BASE + 12'(4 * k);
  endfunction : da

  function automatic logic [15:0] f(input int op, input logic [15:0] x, input logic [15:0] y);
    case (op)
      0: return x & y;
      1: return x | y;
      default: return x ^ y;
    endcase
  endfunction : f

  function automatic wlsu_cfg_t cf(input wlsu_op_t o, input wlsu_kind_t k1, input wlsu_kind_t k2,
      input wlsu_kind_t kd, input logic [2:0] fl, input logic hs);
    return '{hs, fl[2], fl[1], fl[0], kd, k2, k1, o};
  endfunction : cf

  task automatic chkRead(input logic [31:0] e, input logic [19:0] s);
    samplesChecked++;
    if (s !== e[19:0]) begin
      nErrors++;
      $display("unexpected read %h: expected %h seen %h", e[31:20], e[19:0], s);
    end
  endtask : chkRead

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic [11:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, w, 4'h3, a[11:2], {16'h0000, d}};
    rdPend <= !w;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    wbReq <= '0;
    rdPend <= 1'b0;
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    wb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    expQ.push_back({a, |(irqSt & irqMsk), err, err, carry, e});
    wb(a, 1'b0, 16'h0000);
  endtask : rd

  task automatic run(input wlsu_cfg_t c, input logic [15:0] a1, input logic [15:0] a2,
      input logic [15:0] ad, input logic [15:0] cnt);
    int n;
    wr(ADR_CFG, 16'(c));
    wr(ADR_SRC1, a1);
    wr(ADR_SRC2, a2);
    wr(ADR_DST, ad);
    wr(ADR_COUNT, cnt);
    @(posedge clk);
    runReq <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (runDone !== 1'b1 && n < 300);
    runReq <= 1'b0;
    if (n >= 300) nErrors++;
    if (enLevel) irqSt[0] = 1'b1;
  endtask : run

  task automatic flt();
    err = 1'b1;
    irqSt[1] = 1'b1;
  endtask : flt

  task automatic shl(input int s, input int k);
    carry = mem[s][16 - k];
    mem[s] = mem[s] << k;
  endtask : shl

  task automatic finalReport();
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finalReport

  // Takes the oldest note whenever a read answer appears
  always @(posedge clk) begin
    if (rdPend && wbAck === 1'b1 && expQ.size() > 0) begin
      chkRead(expQ.pop_front(), {irq, errorLamp, execErrorRelay, carryRelay, wbDatO[15:0]});
    end
  end

  // Watchdog against a hung handshake
  initial begin
    #4000000;
    nErrors++;
    finalReport();
  end

  // Main sequence
  initial begin
    wbReq = '0;
    runReq = 1'b0;
    enLevel = 1'b1;
    rdPend = 1'b0;
    carry = 1'b0;
    err = 1'b0;
    irqSt = 2'b00;
    irqMsk = 2'b00;
    inputImage = 16'h0000;
    timerCurrent = '0;
    counterCurrent = '0;
    sys_rst = 1'b1;
    for (int i = 0; i < 100; i++) mem[i] = 16'h0000;
    void'($urandom(33));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    inputImage <= 16'($urandom);
    for (int i = 0; i < 32; i++) begin
      timerCurrent[i] <= 16'($urandom);
      counterCurrent[i] <= 16'($urandom);
    end
    rd(ADR_CFG, 16'h0000);
    rd(ADR_STATUS, 16'h0000);
    rd(da(0), 16'h0000);
    rd(TPRE_BASE, 16'h0000);
    wr(12'h0FC, 16'hFFFF);
    rd(12'h0FC, 16'h0000);
    // Each word logic op (AND, OR, XOR) against every repeat combination, repeat count three
    for (int op = 0; op < 3; op++) begin
      for (int fl = 0; fl < 8; fl++) begin
        for (int i = 0; i < 3; i++) begin
          mem[10 + i] = 16'($urandom);
          mem[20 + i] = 16'($urandom);
          wr(da(10 + i), mem[10 + i]);
          wr(da(20 + i), mem[20 + i]);
        end
        run(cf(wlsu_op_t'(op), K_DATA, K_DATA, K_DATA, 3'(fl), 1'b0), 16'hA, 16'h14, 16'h1E,
          16'h3);
        for (int i = 0; i < 3; i++) begin
          mem[30 + (fl[2] ? i : 0)] = f(op, mem[10 + (fl[0] ? i : 0)], mem[20 + (fl[1] ? i : 0)]);
        end
        for (int i = 0; i < 3; i++) begin
          rd(da(30 + i), mem[30 + i]);
        end
      end
    end
    // Timer, counter and input sources; preset destinations
    run(cf(OP_AND, K_TIMER, K_CONST, K_TIMER, 3'h0, 1'b0), 16'h5, 16'h1FFF, 16'h7, 16'h0);
    rd(TPRE_BASE + 12'h01C, timerCurrent[5] & 16'h1FFF);
    run(cf(OP_OR, K_CONST, K_CONST, K_COUNTER, 3'h0, 1'b0), PRESET_MAX, 16'h0, 16'h9, 16'h0);
    rd(CPRE_BASE + 12'h024, PRESET_MAX);
    run(cf(OP_XOR, K_COUNTER, K_INPUT, K_DATA, 3'h0, 1'b0), 16'h2, 16'h0, 16'h32, 16'h0);
    mem[50] = counterCurrent[2] ^ inputImage;
    rd(da(50), mem[50]);
    // Interrupt status, mask and write-one clear
    rd(ADR_IRQ_STAT, 16'h0001);
    wr(ADR_IRQ_MASK, 16'h0001);
    irqMsk = 2'b01;
    rd(ADR_IRQ_MASK, 16'h0001);
    wr(ADR_IRQ_STAT, 16'h0001);
    irqSt = 2'b00;
    rd(ADR_IRQ_STAT, 16'h0000);
    // Shift left held over two scans, then the longest legal shift
    mem[40] = 16'hAAAA;
    wr(da(40), mem[40]);
    repeat (2) begin
      run(cf(OP_SHL, K_DATA, K_DATA, K_DATA, 3'h0, 1'b0), 16'h28, 16'h0, 16'h0, 16'h0100);
      shl(40, 1);
    end
    rd(da(40), mem[40]);
    mem[31] = 16'($urandom);
    wr(da(31), mem[31]);
    run(cf(OP_SHL, K_DATA, K_DATA, K_DATA, 3'h0, 1'b1), 16'h1F, 16'h0, 16'h0, 16'h0F00);
    shl(31, 15);
    rd(da(31), mem[31]);
    enLevel = 1'b0;
    run(cf(OP_SHL, K_DATA, K_DATA, K_DATA, 3'h0, 1'b0), 16'h28, 16'h0, 16'h0, 16'h0100);
    enLevel = 1'b1;
    rd(da(40), mem[40]);
    rd(ADR_STATUS, {13'h0000, carry, err, 1'b0});
    // Preset overflow in the second repeat cycle writes nothing
    mem[60] = 16'h5;
    mem[61] = PRESET_MAX + 16'h1;
    wr(da(60), mem[60]);
    wr(da(61), mem[61]);
    run(cf(OP_OR, K_DATA, K_CONST, K_COUNTER, 3'h5, 1'b0), 16'h3C, 16'h0, 16'h3, 16'h2);
    flt();
    rd(CPRE_BASE + 12'h00C, 16'h0000);
    rd(CPRE_BASE + 12'h010, 16'h0000);
    run(cf(OP_XOR, K_DATA, K_DATA, K_CONST, 3'h0, 1'b0), 16'hA, 16'h14, 16'h1E, 16'h0);
    flt();
    rd(da(30), mem[30]);
    // Refused shifts: repeat flag, high-speed range, zero count
    for (int b = 0; b < 3; b++) begin
      run(cf(OP_SHL, K_DATA, K_DATA, K_DATA, b == 0 ? 3'h1 : 3'h0, b == 1),
        b == 1 ? 16'h20 : 16'h28, 16'h0, 16'h0, b == 2 ? 16'h0 : 16'h0100);
      flt();
      rd(da(b == 1 ? 32 : 40), mem[b == 1 ? 32 : 40]);
    end
    // Later instructions still run with the error latched
    run(cf(OP_XOR, K_DATA, K_DATA, K_DATA, 3'h0, 1'b0), 16'hA, 16'h14, 16'h1E, 16'h0);
    mem[30] = mem[10] ^ mem[20];
    rd(da(30), mem[30]);
    rd(ADR_STATUS, {13'h0000, carry, err, 1'b0});
    rd(ADR_IRQ_STAT, {14'h0000, irqSt});
    finalReport();
  end
endmodule : word_logic_shift_unit_tb_top
